// *** spi_port_cfg.svh ***
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH

// ********************************************************************
// Link constants
// ********************************************************************

// Seven-bit device address that follows every falling chip select.
`define CFG_DEV_ADDR 7'h00
// Direction flag in bit 0 of the address byte; zero means write.
`define CFG_DIR_WRITE 1'b0
// Bit index of the last bit in a byte.
`define CFG_BIT_LAST 3'h7

// ********************************************************************
// Strap capture
// ********************************************************************

// Cycles after reset release before the synchronised straps are valid.
`define CFG_STRAP_WAIT 2'h2

// ********************************************************************
// Host serial clock timing
// ********************************************************************

// System clock period in ns.
`define CFG_SYS_CLK_NS 10
// Least half period of the host-made serial control clock in ns.
`define CFG_SCLK_HALF_NS 30

`endif

// *** spi_port_pkg.sv ***
`default_nettype none

package spi_port_pkg;

  // ********************************************************************
  // Host interface modes, one-hot
  // ********************************************************************

  typedef enum logic [4:0] {
    MODE_NONE  = 5'h01,
    MODE_PAR_A = 5'h02,
    MODE_PAR_B = 5'h04,
    MODE_I2C   = 5'h08,
    MODE_SPI   = 5'h10
  } host_mode_t;

  // ********************************************************************
  // Device state
  // ********************************************************************

  // Per-frame receive state, cleared while chip select is high.
  typedef struct packed {
    logic [6:0] shift;
    logic [2:0] cnt;
    logic addressed;
  } frame_t;

  // Received byte handed across to the processor clock.
  typedef struct packed {
    logic [7:0] word;
    logic tog;
  } handoff_t;

  // Processor clock side of the device.
  typedef struct packed {
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic [1:0] wait_cnt;
    logic captured;
    host_mode_t mode;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic [7:0] rx_data;
    logic rx_valid;
    logic attn_o;
    logic attn_oe_n;
    logic sdo;
    logic sdo_oe_n;
  } dev_sys_t;

  // ********************************************************************
  // Host state
  // ********************************************************************

  typedef enum logic [4:0] {
    H_IDLE   = 5'h01,
    H_LOW    = 5'h02,
    H_HIGH   = 5'h04,
    H_GAP    = 5'h08,
    H_FINISH = 5'h10
  } host_state_t;

  typedef struct packed {
    host_state_t state;
    logic [7:0] div;
    logic [2:0] cnt;
    logic [7:0] shift;
    logic last;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic tx_ready;
    logic attn_s1;
    logic attn_s2;
    logic attention;
  } host_t;

endpackage

`default_nettype wire

// *** spi_link_if.sv ***
`default_nettype none

// ********************************************************************
// Serial control link between host and device
// ********************************************************************

interface spi_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe_n;
  logic attn_o;
  logic attn_oe_n;
  logic sdo_line;
  logic attn_line;

  // Open-drain lines read high through the pull-up when released.
  assign attn_line = attn_oe_n ? 1'b1 : attn_o;
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo;

  modport device (
    input cs_n,
    input sclk,
    input sdi,
    output sdo,
    output sdo_oe_n,
    output attn_o,
    output attn_oe_n
  );

  modport host (
    output cs_n,
    output sclk,
    output sdi,
    input sdo_line,
    input attn_line
  );
endinterface

`default_nettype wire

// *** spi_write_host.sv ***
`include "spi_port_cfg.svh"
`default_nettype none

// ********************************************************************
// Host end: frames bytes onto the serial control link
// ********************************************************************

module spi_write_host
  import spi_port_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `CFG_DEV_ADDR
)(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Byte stream to send.
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  // Device wants to be read.
  output logic attention,
  // Link.
  spi_link_if.host link
);

  // Half period of the serial clock in system cycles, rounded up.
  localparam int HALF_CYC = (`CFG_SCLK_HALF_NS + `CFG_SYS_CLK_NS - 1) / `CFG_SYS_CLK_NS;
  localparam logic [7:0] HALF_RELOAD = 8'(HALF_CYC - 1);
  localparam logic [7:0] ADDR_BYTE = {DEV_ADDR, `CFG_DIR_WRITE};

  host_t r_reg;
  host_t r_next;
  logic tick;

  // ********************************************************************
  // Next state
  // ********************************************************************

  // The divider, restarted when a byte leaves the gap, paces every half period of the clock.
  always_comb
  begin
    r_next = r_reg;
    tick = (r_reg.div == 8'h00);
    r_next.div = tick ? HALF_RELOAD : r_reg.div - 8'h01;
    r_next.attn_s1 = link.attn_line;
    r_next.attn_s2 = r_reg.attn_s1;
    r_next.attention = ~r_reg.attn_s2;
    case (r_reg.state)
      H_IDLE:
      begin
        // A frame opens with chip select low and the address byte.
        if (tick && tx_valid)
        begin
          r_next.cs_n = 1'b0;
          r_next.shift = ADDR_BYTE;
          r_next.sdi = ADDR_BYTE[7];
          r_next.cnt = 3'h0;
          r_next.last = 1'b0;
          r_next.state = H_LOW;
        end
      end
      H_LOW:
      begin
        if (tick)
        begin
          r_next.sclk = 1'b1;
          r_next.state = H_HIGH;
        end
      end
      H_HIGH:
      begin
        if (tick)
        begin
          r_next.sclk = 1'b0;
          r_next.cnt = r_reg.cnt + 3'h1;
          if (r_reg.cnt == `CFG_BIT_LAST)
          begin
            // The last falling edge is made before chip select rises.
            if (r_reg.last)
            begin
              r_next.state = H_FINISH;
            end
            else
            begin
              r_next.state = H_GAP;
              r_next.tx_ready = 1'b1;
            end
          end
          else
          begin
            r_next.shift = {r_reg.shift[6:0], 1'b0};
            r_next.sdi = r_reg.shift[6];
            r_next.state = H_LOW;
          end
        end
      end
      H_GAP:
      begin
        // Clock rests low until the next byte is offered.
        if (tx_valid && r_reg.tx_ready)
        begin
          r_next.tx_ready = 1'b0;
          r_next.shift = tx_data;
          r_next.sdi = tx_data[7];
          r_next.last = tx_last;
          r_next.div = HALF_RELOAD;
          r_next.state = H_LOW;
        end
      end
      H_FINISH:
      begin
        if (tick)
        begin
          r_next.cs_n = 1'b1;
          r_next.state = H_IDLE;
        end
      end
      default:
      begin
        r_next.state = H_IDLE;
      end
    endcase
  end

  // ********************************************************************
  // State register
  // ********************************************************************

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_reg <= '{state: H_IDLE, div: 8'h00, cnt: 3'h0, shift: 8'h00, last: 1'b0,
                 cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0, tx_ready: 1'b0,
                 attn_s1: 1'b1, attn_s2: 1'b1, attention: 1'b0};
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Pins and user outputs come straight from the state register.
  assign link.cs_n = r_reg.cs_n;
  assign link.sclk = r_reg.sclk;
  assign link.sdi = r_reg.sdi;
  assign tx_ready = r_reg.tx_ready;
  assign attention = r_reg.attention;

endmodule

`default_nettype wire

// *** spi_write_device.sv ***

`include "spi_port_cfg.svh"
`default_nettype none

// ********************************************************************
// Device end: serial write port and host mode straps
// ********************************************************************

module spi_write_device
  import spi_port_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `CFG_DEV_ADDR
)(
  // Processor clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Host mode straps.
  input wire logic strap_read,
  input wire logic strap_write,
  input wire logic strap_style,
  // Processor side.
  input wire logic msg_pending,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output host_mode_t host_mode,
  // Link.
  spi_link_if.device link
);

  localparam logic [7:0] ADDR_BYTE = {DEV_ADDR, `CFG_DIR_WRITE};

  // ********************************************************************
  // Link clock domain
  // ********************************************************************

  frame_t frame_reg;
  frame_t frame_next;
  handoff_t hand_reg;
  handoff_t hand_next;
  logic sample_reg;
  logic link_clr;
  logic [7:0] full_byte;

  // A high chip select holds the frame logic cleared, so every frame
  // opens with a fresh bit count and expects an address byte.
  assign link_clr = link.cs_n | ~rst_n;

  // Data is taken on the rising clock edge, mid-bit.
  always_ff @(posedge link.sclk or posedge link_clr)
  begin
    if (link_clr)
    begin
      sample_reg <= 1'b0;
    end
    else
    begin
      sample_reg <= link.sdi;
    end
  end

  // Bits are shifted in on falling edges; the eighth closes the byte.
  always_comb
  begin
    frame_next = frame_reg;
    hand_next = hand_reg;
    full_byte = {frame_reg.shift, sample_reg};
    frame_next.shift = full_byte[6:0];
    frame_next.cnt = frame_reg.cnt + 3'h1;
    if (frame_reg.cnt == `CFG_BIT_LAST)
    begin
      if (!frame_reg.addressed)
      begin
        // Address and write direction must match before data counts.
        frame_next.addressed = (full_byte == ADDR_BYTE);
      end
      else
      begin
        // No length limit: every further byte is handed over alike.
        hand_next.word = full_byte;
        hand_next.tog = ~hand_reg.tog;
      end
    end
  end

  // Frame state; chip select high clears it at once.
  always_ff @(negedge link.sclk or posedge link_clr)
  begin
    if (link_clr)
    begin
      frame_reg <= '{shift: 7'h00, cnt: 3'h0, addressed: 1'b0};
    end
    else
    begin
      frame_reg <= frame_next;
    end
  end

  // The handoff toggle survives chip select so no false edge appears.
  always_ff @(negedge link.sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hand_reg <= '{word: 8'h00, tog: 1'b0};
    end
    else
    begin
      hand_reg <= hand_next;
    end
  end

  // ********************************************************************
  // Processor clock domain
  // ********************************************************************

  dev_sys_t s_reg;
  dev_sys_t s_next;
  logic strap_rd;
  logic strap_wr;
  logic strap_ps;
  logic serial_mode;

  assign strap_rd = s_reg.strap_s2[2];
  assign strap_wr = s_reg.strap_s2[1];
  assign strap_ps = s_reg.strap_s2[0];
  assign serial_mode = (s_reg.mode == MODE_SPI) || (s_reg.mode == MODE_I2C);

  // Strap capture, byte pickup and request line drive.
  always_comb
  begin
    s_next = s_reg;
    s_next.strap_s1 = {strap_read, strap_write, strap_style};
    s_next.strap_s2 = s_reg.strap_s1;
    s_next.rx_valid = 1'b0;
    // Straps settle through the synchroniser, then are caught once.
    if (!s_reg.captured)
    begin
      if (s_reg.wait_cnt == `CFG_STRAP_WAIT)
      begin
        s_next.captured = 1'b1;
        case ({strap_rd, strap_wr})
          2'b11:
          begin
            s_next.mode = strap_ps ? MODE_PAR_A : MODE_PAR_B;
          end
          2'b01:
          begin
            s_next.mode = MODE_I2C;
          end
          2'b10:
          begin
            s_next.mode = MODE_SPI;
          end
          default:
          begin
            s_next.mode = MODE_NONE;
          end
        endcase
      end
      else
      begin
        s_next.wait_cnt = s_reg.wait_cnt + 2'h1;
      end
    end
    // Toggle crossing; the word is stable long before the edge arrives.
    s_next.tog_s1 = hand_reg.tog;
    s_next.tog_s2 = s_reg.tog_s1;
    s_next.tog_s3 = s_reg.tog_s2;
    if ((s_reg.tog_s2 != s_reg.tog_s3) && (s_reg.mode == MODE_SPI))
    begin
      s_next.rx_data = hand_reg.word;
      s_next.rx_valid = 1'b1;
    end
    // Request line pulls low only while a message waits for the host and the mode is SPI or I2C.
    s_next.attn_o = 1'b0;
    s_next.attn_oe_n = ~(msg_pending && serial_mode);
    // The read path is not built; data out stays released.
    s_next.sdo = 1'b0;
    s_next.sdo_oe_n = 1'b1;
  end

  // Processor clock state register.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= '{strap_s1: 3'h0, strap_s2: 3'h0, wait_cnt: 2'h0, captured: 1'b0,
                 mode: MODE_NONE, tog_s1: 1'b0, tog_s2: 1'b0, tog_s3: 1'b0,
                 rx_data: 8'h00, rx_valid: 1'b0, attn_o: 1'b0, attn_oe_n: 1'b1,
                 sdo: 1'b0, sdo_oe_n: 1'b1};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs come straight from the state register.
  assign rx_data = s_reg.rx_data;
  assign rx_valid = s_reg.rx_valid;
  assign host_mode = s_reg.mode;
  assign link.attn_o = s_reg.attn_o;
  assign link.attn_oe_n = s_reg.attn_oe_n;
  assign link.sdo = s_reg.sdo;
  assign link.sdo_oe_n = s_reg.sdo_oe_n;

endmodule

`default_nettype wire

// *** spi_link_props.sv ***
`default_nettype none

// ********************************************************************
// Wire checks on the host to device serial link
// ********************************************************************

module spi_link_props
  import spi_port_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link lines.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  input wire logic attn_o,
  input wire logic attn_oe_n,
  input wire logic sdo_line,
  input wire logic attn_line
);
  logic sclk_reg;
  logic [15:0] rise_reg;

  // Counts serial clock rises within a frame so byte boundaries can be judged.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_reg <= 1'b0;
      rise_reg <= 16'h0000;
    end
    else
    begin
      sclk_reg <= sclk;
      if (cs_n)
        rise_reg <= 16'h0000;
      else if (sclk && !sclk_reg)
        rise_reg <= rise_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // The high half of a serial clock pulse lasts three processor cycles; the low half lasts at least three.
  sequence s_high_half;
    sclk [*3];
  endsequence
  sequence s_low_half;
    !sclk [*3];
  endsequence

  chk_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("Serial clock high while chip select is high.");
  chk_select_fall_gap: assert property ($fell(cs_n) |-> !sclk [*2])
    else $error("Serial clock rose too soon after chip select fell.");
  chk_pulse_high: assert property ($rose(sclk) |-> s_high_half ##1 !sclk)
    else $error("Serial clock high phase has the wrong length.");
  chk_pulse_low: assert property ($fell(sclk) |-> s_low_half)
    else $error("Serial clock low phase too short.");
  chk_sdi_steady: assert property (sclk && $past(sclk) |-> $stable(sdi))
    else $error("Data line moved while the serial clock was high.");
  chk_address_write: assert property ($rose(sclk) && rise_reg < 16'h0008 |-> !sdi)
    else $error("Address byte bit is not zero.");
  chk_whole_bytes: assert property (
    $rose(cs_n) |-> rise_reg[2:0] == 3'h0 && rise_reg >= 16'h0010)
    else $error("Frame did not end on a whole byte after the address.");
  chk_last_fall_first: assert property ($rose(cs_n) |-> !$past(sclk) && !$past(sclk, 2))
    else $error("Chip select rose before the last clock fall settled.");
  chk_read_released: assert property (sdo_oe_n && sdo_line)
    else $error("Serial data out is driven in a write-only port.");
  chk_request_drain: assert property (!attn_oe_n |-> !attn_o && !attn_line)
    else $error("Request line not pulled low while enabled.");
endmodule

`default_nettype wire

// *** host_mode_select_spi_write_port_tb.sv ***
`default_nettype none

// ********************************************************************
// Bench for the host and device ends of the serial write port
// ********************************************************************

module host_mode_select_spi_write_port_tb
  import spi_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] straps = 3'h4;
  logic msg_pending = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_last = 1'b0;
  logic tx_valid = 1'b0;
  logic tx_ready;
  logic attention;
  logic [7:0] rx_data;
  logic [7:0] rx_data2;
  logic rx_valid;
  logic rx_valid2;
  host_mode_t host_mode;
  host_mode_t host_mode2;
  int fail_count = 0;
  int n_compared = 0;
  logic [7:0] exp_q[$];
  logic [7:0] exp2_q[$];
  realtime t_fall = 0.0;

  spi_link_if link();
  spi_link_if link2();

  always #5 sys_clk = ~sys_clk;

  spi_write_host i_spi_write_host (.sys_clk(sys_clk), .rst_n(rst_n), .tx_data(tx_data),
    .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .attention(attention),
    .link(link));
  spi_write_device i_spi_write_device (.sys_clk(sys_clk), .rst_n(rst_n),
    .strap_read(straps[2]), .strap_write(straps[1]), .strap_style(straps[0]),
    .msg_pending(msg_pending), .rx_data(rx_data), .rx_valid(rx_valid),
    .host_mode(host_mode), .link(link));
  // Second device whose link the bench drives directly, rules broken on purpose.
  spi_write_device i_spi_write_device_fault (.sys_clk(sys_clk), .rst_n(rst_n),
    .strap_read(straps[2]), .strap_write(straps[1]), .strap_style(straps[0]),
    .msg_pending(msg_pending), .rx_data(rx_data2), .rx_valid(rx_valid2),
    .host_mode(host_mode2), .link(link2));
  spi_link_props i_spi_link_props (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(link.cs_n),
    .sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe_n(link.sdo_oe_n),
    .attn_o(link.attn_o), .attn_oe_n(link.attn_oe_n), .sdo_line(link.sdo_line),
    .attn_line(link.attn_line));

  task automatic check(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Reference decode of the three strap levels, read then write then style.
  function automatic host_mode_t exp_mode(input logic [2:0] c);
    case (c)
      3'h7: return MODE_PAR_A;
      3'h6: return MODE_PAR_B;
      3'h2, 3'h3: return MODE_I2C;
      3'h4, 3'h5: return MODE_SPI;
      default: return MODE_NONE;
    endcase
  endfunction

  // Resets with the given straps, then moves the straps to show the mode holds.
  task automatic strap_reset(input logic [2:0] code);
    host_mode_t m;
    logic ser;
    @(negedge sys_clk);
    rst_n = 1'b0;
    straps = code;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (12) @(negedge sys_clk);
    m = exp_mode(code);
    ser = (m == MODE_I2C || m == MODE_SPI);
    check(host_mode === m && host_mode2 === m, "mode decode");
    check(link.attn_line === !ser && attention === ser, "request line");
    straps = ~code;
    repeat (4) @(negedge sys_clk);
    check(host_mode === m, "mode not held");
  endtask

  // Sends one frame of random bytes through the host end with random gaps.
  task automatic send_frame(input int n);
    int k;
    for (int i = 0; i < n; i++)
    begin
      tx_data = 8'($urandom);
      tx_last = (i == n - 1);
      tx_valid = 1'b1;
      exp_q.push_back(tx_data);
      k = 0;
      while (tx_ready !== 1'b1 && k < 400)
      begin
        @(negedge sys_clk);
        k++;
      end
      check(k < 400, "host never ready");
      @(negedge sys_clk);
      if (i == n - 1 || $urandom_range(1, 0) == 1)
      begin
        tx_valid = 1'b0;
        repeat ($urandom_range(9, 1)) @(negedge sys_clk);
      end
    end
    k = 0;
    while (link.cs_n !== 1'b1 && k < 400)
    begin
      @(negedge sys_clk);
      k++;
    end
    repeat (10) @(negedge sys_clk);
    check(exp_q.size() == 0, "frame not delivered");
  endtask

  // Shifts bits of one byte onto the second link, 48 ns per clock.
  task automatic bb_byte(input logic [7:0] b, input int nbits);
    for (int i = 7; i > 7 - nbits; i--)
    begin
      link2.sdi = b[i];
      #24 link2.sclk = 1'b1;
      #24 link2.sclk = 1'b0;
    end
    t_fall = $realtime;
  endtask

  // One frame on the second link: address, n random bytes, then a partial tail.
  task automatic bb_frame(input logic [7:0] addr, input int n, input int tail, input bit keep);
    logic [7:0] d;
    link2.cs_n = 1'b0;
    #24;
    bb_byte(addr, 8);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      if (keep)
        exp2_q.push_back(d);
      bb_byte(d, 8);
    end
    if (tail > 0)
      bb_byte(8'h5a, tail);
    #24 link2.cs_n = 1'b1;
    link2.sdi = ~link2.sdi;
    #240;
  endtask

  // Compares every delivered byte with the reference queues.
  always @(negedge sys_clk)
  begin
    if (rx_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(1'b0, "unexpected byte");
      else
        check(rx_data === exp_q.pop_front(), "byte value");
    end
    if (rx_valid2 === 1'b1)
    begin
      check($realtime - t_fall >= 20.0 && $realtime - t_fall <= 55.0, "handoff delay");
      if (exp2_q.size() == 0)
        check(1'b0, "byte from refused frame");
      else
        check(rx_data2 === exp2_q.pop_front(), "fault link byte");
    end
  end

  // Cuts a hang short.
  initial
  begin
    #300000;
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end

  // Main sequence.
  initial
  begin
    link2.cs_n = 1'b1;
    link2.sclk = 1'b0;
    link2.sdi = 1'b0;
    void'($urandom(87));
    msg_pending = 1'b1;
    for (int c = 0; c < 8; c++)
      strap_reset(3'(c));
    bb_frame(8'h00, 1, 0, 1'b0);
    strap_reset(3'h4);
    msg_pending = 1'b0;
    repeat (8) @(negedge sys_clk);
    check(link.attn_line === 1'b1 && attention === 1'b0, "request not released");
    send_frame(1);
    send_frame(2);
    send_frame(5);
    send_frame(3);
    bb_frame(8'h01, 1, 0, 1'b0);
    bb_frame(8'h02, 1, 0, 1'b0);
    bb_frame(8'h00, 0, 5, 1'b0);
    bb_frame(8'h00, 2, 3, 1'b1);
    bb_frame(8'h00, 1, 0, 1'b1);
    #500;
    check(exp2_q.size() == 0, "fault link bytes missing");
    tally_and_finish();
  end
endmodule

`default_nettype wire
